// file: otd_pkg.sv
// Purpose: Shared constants for the on-chip bus trace debug unit.
// Assumes: 32-bit APB, byte offsets, one word per register.
// Notes: Trigger mode codes follow the four-bit mode field.
package otd_pkg;
  localparam int AW         = 16;
  localparam int DW         = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int TQ_DEPTH   = 4;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CMPA    = 8'h04;
  localparam logic [7:0] REG_CMPB    = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_FIFO_HI = 8'h10;
  localparam logic [7:0] REG_FIFO_LO = 8'h14;

  localparam int CTRL_ARM    = 0;
  localparam int CTRL_BRKEN  = 1;
  localparam int CTRL_TAG    = 2;
  localparam int CTRL_BEGIN  = 3;
  localparam int CTRL_TAG_TRIGGER_SELECT = 4;
  localparam int CTRL_CMP_A_RW_QUALIFY_EN  = 5;
  localparam int CTRL_RWA    = 6;
  localparam int CTRL_RWBEN  = 7;
  localparam int CTRL_RWB    = 8;
  localparam int CTRL_MODE   = 12;
  localparam int STAT_ARMED  = 0;
  localparam int STAT_AF     = 1;
  localparam int STAT_BF     = 2;
  localparam int STAT_CNT    = 4;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'h0000;

  localparam logic [3:0] MODE_A_ONLY  = 4'h0;
  localparam logic [3:0] MODE_A_OR_B  = 4'h1;
  localparam logic [3:0] MODE_A_THN_B = 4'h2;
  localparam logic [3:0] MODE_EVT_B   = 4'h3;
  localparam logic [3:0] MODE_A_EVT_B = 4'h4;
  localparam logic [3:0] MODE_A_B_DAT = 4'h5;
  localparam logic [3:0] MODE_A_NB_DAT = 4'h6;
  localparam logic [3:0] MODE_INSIDE  = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;

  localparam logic [1:0] COF_NONE   = 2'h0;
  localparam logic [1:0] COF_UNCOND = 2'h1;
  localparam logic [1:0] COF_BRANCH = 2'h2;
  localparam logic [1:0] COF_TARGET = 2'h3;

  localparam logic [1:0] COF_SKIP = 2'h2;

  typedef enum {RUN_IDLE, RUN_WAIT, RUN_CAPT} otd_run_t;
endpackage : otd_pkg

// file: otd_trace.sv
// Purpose: Bus trace debug unit with two comparators, trigger logic and FIFO.
// Assumes: CPU bus signals come from logic on MCLK_I; registers on APB.
// Notes: Low-byte FIFO reads shift the FIFO; reads take effect in access phase.
//
// The register offsets and the APB register port were decided locally.
module otd_trace
  import otd_pkg::*;
(
  input  wire logic                  MCLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [7:0]            PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  input  wire logic [otd_pkg::AW-1:0] CPU_ADDR_I,
  input  wire logic [otd_pkg::DW-1:0] CPU_RDATA_I,
  input  wire logic [otd_pkg::DW-1:0] CPU_WDATA_I,
  input  wire logic                  CPU_RW_I,
  input  wire logic                  CPU_VALID_I,
  input  wire logic                  CPU_OPFETCH_I,
  input  wire logic                  SDC_ACCESS_I,
  input  wire logic                  QUEUE_EXEC_I,
  input  wire logic                  QUEUE_FLUSH_I,
  input  wire logic [1:0]            COF_TYPE_I,
  input  wire logic [otd_pkg::AW-1:0] COF_ADDR_I,
  output logic                       BRK_TAG_O,
  output logic                       BRK_FORCE_O
);
  import otd_pkg::*;

  logic [15:0]   ctrl;
  logic [15:0]   cmpa;
  logic [15:0]   cmpb;
  otd_run_t      st;
  logic          af;
  logic          bf;
  logic [3:0]    cnt;
  logic [1:0]    skip;
  logic [15:0]   fifo [FIFO_DEPTH];
  logic [15:0]   last_op;
  logic [TQ_DEPTH-1:0] tq [2];
  logic [2:0]    tc [2];
  logic          hit_tr [2];

  function automatic logic is_event_mode(input logic [3:0] m);
    return (m == MODE_EVT_B) || (m == MODE_A_EVT_B);
  endfunction : is_event_mode

  wire [3:0] mode = ctrl[CTRL_MODE+:4];
  wire acc    = PSEL_I & PENABLE_I;
  wire wr_acc = acc & PWRITE_I;
  wire rd_low = acc & ~PWRITE_I & (PADDR_I == REG_FIFO_LO);
  wire wr_ctl = wr_acc & (PADDR_I == REG_CTRL);
  wire arm1   = wr_ctl & PWDATA_I[CTRL_ARM];
  wire arm0   = wr_ctl & ~PWDATA_I[CTRL_ARM];
  wire armed  = (st != RUN_IDLE);
  wire halt_sh = arm0 & armed & (cnt < 4'(FIFO_DEPTH));
  wire bus    = CPU_VALID_I & ~SDC_ACCESS_I;
  wire evt    = is_event_mode(mode);
  wire begin_t = ctrl[CTRL_BEGIN] | evt;
  wire full_m = (mode == MODE_A_B_DAT) | (mode == MODE_A_NB_DAT);

  // The run type comes from the word being written, since ctrl only takes it at this same edge.
  wire [3:0] wr_mode = PWDATA_I[CTRL_MODE+:4];
  wire wr_evt   = is_event_mode(wr_mode);
  wire wr_begin = PWDATA_I[CTRL_BEGIN] & ~wr_evt;

  // Data compare bus choice only matters in the full modes.
  wire use_wr = ctrl[CTRL_CMP_A_RW_QUALIFY_EN] & ~ctrl[CTRL_RWA];
  wire [7:0] bdat = use_wr ? CPU_WDATA_I : CPU_RDATA_I;
  wire [7:0] edat = CPU_RW_I ? CPU_RDATA_I : CPU_WDATA_I;
  wire qa = ~ctrl[CTRL_CMP_A_RW_QUALIFY_EN] | (CPU_RW_I == ctrl[CTRL_RWA]);
  wire qb = ~ctrl[CTRL_RWBEN] | (CPU_RW_I == ctrl[CTRL_RWB]);
  wire a_m = bus & qa & (CPU_ADDR_I == cmpa);
  wire b_m = bus & qb & (CPU_ADDR_I == cmpb);
  wire b_dm = bdat == cmpb[7:0];
  wire ge_a = CPU_ADDR_I >= cmpa;
  wire le_b = CPU_ADDR_I <= cmpb;
  // Tracked hits fire at execution, so a debug access in that cycle must mask them too.
  wire a_hit = ctrl[CTRL_TAG_TRIGGER_SELECT] ? (hit_tr[0] & ~SDC_ACCESS_I) : a_m;
  wire b_hit = ctrl[CTRL_TAG_TRIGGER_SELECT] ? (hit_tr[1] & ~SDC_ACCESS_I) : b_m;

  // The tag queues mirror the CPU instruction queue, one per comparator.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_track
      wire m = (g == 0) ? a_m : b_m;
      logic [TQ_DEPTH-1:0] next_q;
      logic [2:0]          next_c;
      logic [2:0]          idx;
      assign hit_tr[g] = QUEUE_EXEC_I & (tc[g] != 3'h0) & tq[g][0];
      always_comb begin
        next_q = tq[g];
        next_c = tc[g];
        if (QUEUE_EXEC_I && tc[g] != 3'h0) begin
          next_q = tq[g] >> 1;
          next_c = tc[g] - 3'h1;
        end
        idx = next_c;
        if (bus && CPU_OPFETCH_I && next_c < 3'(TQ_DEPTH)) begin
          next_q[idx[1:0]] = m;
          next_c = next_c + 3'h1;
        end
      end
      always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          tq[g] <= '0;
          tc[g] <= 3'h0;
        end else if (QUEUE_FLUSH_I) begin
          tc[g] <= 3'h0;
        end else begin
          tq[g] <= next_q;
          tc[g] <= next_c;
        end
      end
    end
  endgenerate

  logic trig;
  always_comb begin
    unique case (mode)
      MODE_A_ONLY:   trig = a_hit;
      MODE_A_OR_B:   trig = a_hit | b_hit;
      MODE_A_THN_B:  trig = af & b_hit;
      MODE_EVT_B:    trig = b_hit;
      MODE_A_EVT_B:  trig = af & b_hit;
      MODE_A_B_DAT:  trig = a_m & b_dm;
      MODE_A_NB_DAT: trig = a_m & ~b_dm;
      MODE_INSIDE:   trig = bus & qa & ge_a & le_b;
      MODE_OUTSIDE:  trig = bus & qa & ~(ge_a & le_b);
      default:       trig = 1'b0;
    endcase
    trig = trig & armed;
  end

  wire cof_ok = (COF_TYPE_I == COF_BRANCH) | (COF_TYPE_I == COF_TARGET);
  wire cap_push = (st == RUN_CAPT) & (evt ? trig : (cof_ok & (skip == 2'h0)));
  wire [15:0] cap_dat = evt ? {8'h00, edat} : COF_ADDR_I;
  wire full_end = begin_t & cap_push & (cnt == 4'(FIFO_DEPTH - 1));

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st   <= RUN_IDLE;
      skip <= 2'h0;
    end else begin
      if (skip != 2'h0 && bus)
        skip <= skip - 2'h1;
      unique case (st)
        RUN_IDLE: if (arm1) begin
          st   <= wr_begin ? RUN_WAIT : RUN_CAPT;
          skip <= 2'h0;
        end
        RUN_WAIT: if (trig) begin
          st   <= RUN_CAPT;
          skip <= COF_SKIP;
        end
        RUN_CAPT: if (full_end || (!begin_t && trig))
          st <= RUN_IDLE;
      endcase
      if (arm0)
        st <= RUN_IDLE;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      af <= 1'b0;
      bf <= 1'b0;
    end else begin
      if (arm1) begin
        af <= 1'b0;
        bf <= 1'b0;
      end
      if (armed && a_hit)
        af <= 1'b1;
      if (armed && b_hit)
        bf <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      cnt <= 4'h0;
    else if (arm1)
      cnt <= 4'h0;
    else if (cap_push && cnt < 4'(FIFO_DEPTH))
      cnt <= cnt + 4'h1;
    else if (rd_low && !cap_push && cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end

  // A capture and a low read in the same cycle share one shift.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < FIFO_DEPTH; i++)
        fifo[i] <= 16'h0000;
    end else if (cap_push || rd_low || halt_sh) begin
      for (int i = 1; i < FIFO_DEPTH; i++)
        fifo[i] <= fifo[i-1];
      if (cap_push)
        fifo[0] <= cap_dat;
      else if (rd_low && !armed)
        fifo[0] <= last_op;
      else
        fifo[0] <= 16'h0000;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      last_op <= 16'h0000;
    else if (CPU_VALID_I && CPU_OPFETCH_I)
      last_op <= CPU_ADDR_I;
  end

  // The tag marker must ride with the fetch, so it is not registered.
  wire brk_on = armed & ctrl[CTRL_BRKEN];
  // In full modes only the A address match may tag, the B half holds data.
  assign BRK_TAG_O = brk_on & ctrl[CTRL_TAG] & CPU_OPFETCH_I & (a_m | (b_m & ~evt & ~full_m));

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      BRK_FORCE_O <= 1'b0;
    else
      BRK_FORCE_O <= brk_on & ~ctrl[CTRL_TAG] & trig;
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= CTRL_RST;
      cmpa <= CMP_RST;
      cmpb <= CMP_RST;
    end else if (wr_acc) begin
      if (PADDR_I == REG_CTRL)
        ctrl <= PWDATA_I[15:0] & ~16'h0001;
      if (PADDR_I == REG_CMPA)
        cmpa <= PWDATA_I[15:0];
      if (PADDR_I == REG_CMPB)
        cmpb <= PWDATA_I[15:0];
    end
  end

  wire mapped = (PADDR_I <= REG_FIFO_LO) & (PADDR_I[1:0] == 2'h0);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc & ~mapped;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      PRDATA_O <= 32'h0000_0000;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        REG_CTRL:    PRDATA_O <= {16'h0000, ctrl[15:1], armed};
        REG_CMPA:    PRDATA_O <= {16'h0000, cmpa};
        REG_CMPB:    PRDATA_O <= {16'h0000, cmpb};
        REG_STATUS:  PRDATA_O <= {24'h0, cnt, 1'b0, bf, af, armed};
        REG_FIFO_HI: PRDATA_O <= {24'h0, fifo[FIFO_DEPTH-1][15:8]};
        REG_FIFO_LO: PRDATA_O <= {24'h0, fifo[FIFO_DEPTH-1][7:0]};
        default:     PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  cnt_max_a: assert property (cnt <= 4'(FIFO_DEPTH)) else $error("Count above eight.");
  arm_clr_a: assert property (arm1 |=> (cnt == 4'h0) && armed && !af && !bf)
    else $error("Arm did not clear state.");
  sdc_quiet_a: assert property (SDC_ACCESS_I |-> !a_m && !b_m && !trig)
    else $error("Match during debug access.");
  full_end_a: assert property (full_end && !arm1 |=> st == RUN_IDLE && cnt == 4'(FIFO_DEPTH))
    else $error("Begin run did not end at full.");
  low_shift_a: assert property (rd_low && !cap_push |=> fifo[FIFO_DEPTH-1] == $past(fifo[FIFO_DEPTH-2]))
    else $error("Low read did not advance.");
  prof_push_a: assert property (rd_low && !armed && !arm1 |=> fifo[0] == $past(last_op))
    else $error("Profile address not pushed.");
  force_brk_a: assert property (trig && brk_on && !ctrl[CTRL_TAG] |=> BRK_FORCE_O)
    else $error("Force break missing.");
  uncond_a: assert property (COF_TYPE_I == COF_UNCOND && !evt |-> !cap_push)
    else $error("Unconditional branch stored.");
  skip_a: assert property (st == RUN_WAIT && trig && !evt && !arm0 |-> !cap_push ##1 !cap_push[*1])
    else $error("Flow change stored at trigger.");

  // Run control.
  evt_begin_a: assert property (
    arm1 && st == RUN_IDLE && wr_evt |=> st == RUN_CAPT)
    else $error("Event run did not capture at once.");
  wait_arm_a: assert property (
    arm1 && st == RUN_IDLE && wr_begin |=> st == RUN_WAIT)
    else $error("Begin run did not wait for trigger.");
  end_trig_a: assert property (
    st == RUN_CAPT && !begin_t && trig && !arm1 |=> st == RUN_IDLE)
    else $error("End run did not stop at trigger.");
  halt_a: assert property (
    arm0 |=> !armed)
    else $error("Manual halt did not stop run.");
  armed_trig_a: assert property (
    !armed |-> !trig)
    else $error("Trigger while not armed.");
  mode_none_a: assert property (
    mode > MODE_OUTSIDE |-> !trig)
    else $error("Unused mode triggered.");
  flag_set_a: assert property (
    armed && a_hit |=> af)
    else $error("A flag not set on match.");

  // FIFO and count.
  halt_shift_a: assert property (
    halt_sh && !cap_push |=> fifo[0] == 16'h0000 && fifo[1] == $past(fifo[0]))
    else $error("Halt did not shift once.");
  cap_count_a: assert property (
    cap_push && !arm1 && cnt < 4'(FIFO_DEPTH) |=> cnt == $past(cnt) + 4'h1)
    else $error("Count did not follow capture.");
  cap_store_a: assert property (
    cap_push |=> fifo[0] == $past(cap_dat))
    else $error("Captured word not stored.");
  evt_high_a: assert property (
    cap_push && evt |=> fifo[0][15:8] == 8'h00)
    else $error("Event entry high byte used.");
  low_dec_a: assert property (
    rd_low && !cap_push && !arm1 && cnt != 4'h0 |=> cnt == $past(cnt) - 4'h1)
    else $error("Low read did not drop count.");
  no_cap_idle_a: assert property (
    st == RUN_IDLE |-> !cap_push)
    else $error("Capture after run ended.");

  // Flow changes.
  cof_none_a: assert property (
    COF_TYPE_I == COF_NONE && !evt |-> !cap_push)
    else $error("Plain cycle stored as flow change.");
  cof_hold_a: assert property (
    st == RUN_CAPT && !evt && skip != 2'h0 |-> !cap_push)
    else $error("Flow change stored while skipping.");
  skip_load_a: assert property (
    st == RUN_WAIT && trig && !arm0 |=> skip == COF_SKIP)
    else $error("Skip window not loaded.");
  end_last_a: assert property (
    st == RUN_CAPT && !evt && trig && cof_ok && skip == 2'h0 |-> cap_push)
    else $error("End trigger flow change lost.");

  // Comparators and breaks.
  wr_data_a: assert property (
    mode == MODE_A_B_DAT && armed && a_m && ctrl[CTRL_CMP_A_RW_QUALIFY_EN] && !ctrl[CTRL_RWA] && CPU_WDATA_I == cmpb[7:0] |-> trig)
    else $error("Write data compare missed.");
  rd_data_a: assert property (
    mode == MODE_A_B_DAT && armed && a_m && !ctrl[CTRL_CMP_A_RW_QUALIFY_EN] && CPU_RDATA_I == cmpb[7:0] |-> trig)
    else $error("Read data compare missed.");
  inside_a: assert property (
    mode == MODE_INSIDE && armed && bus && qa && CPU_ADDR_I >= cmpa && CPU_ADDR_I <= cmpb |-> trig)
    else $error("Inside range missed.");
  outside_a: assert property (
    mode == MODE_OUTSIDE && armed && bus && qa && CPU_ADDR_I < cmpa |-> trig)
    else $error("Outside range missed.");
  tag_only_a: assert property (
    ctrl[CTRL_TAG_TRIGGER_SELECT] && !QUEUE_EXEC_I |-> !a_hit && !b_hit)
    else $error("Tracked hit without execution.");
  tag_brk_a: assert property (
    BRK_TAG_O |-> CPU_OPFETCH_I && armed)
    else $error("Tag outside an opcode fetch.");
  force_src_a: assert property (
    BRK_FORCE_O |-> $past(trig) && !$past(ctrl[CTRL_TAG]))
    else $error("Force break without trigger.");
  tq_depth_a: assert property (
    tc[0] <= 3'(TQ_DEPTH) && tc[1] <= 3'(TQ_DEPTH))
    else $error("Tag queue overfilled.");
  flush_a: assert property (
    QUEUE_FLUSH_I |=> tc[0] == 3'h0 && tc[1] == 3'h0)
    else $error("Tag queue not flushed.");
endmodule : otd_trace

// file: otd_cpu_model.sv
// Purpose: CPU bus partner model for the trace unit.
// Assumes: Signals change just after a rising clock edge.
// Notes: Released buses show inverted values, so a stale copy is never mistaken for data.
module otd_cpu_model
  import otd_pkg::*;
(
  input  wire logic          clk_i,
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      rdata_o,
  output logic [DW-1:0]      wdata_o,
  output logic               rw_o,
  output logic               valid_o,
  output logic               op_o,
  output logic               sdc_o,
  output logic               exec_o,
  output logic               flush_o,
  output logic [1:0]         cof_o,
  output logic [AW-1:0]      cof_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_o, rdata_o, wdata_o, cof_addr_o} = '0;
    {rw_o, valid_o, op_o, sdc_o, exec_o, flush_o, cof_o} = '0;
  end

  task automatic start(input logic [AW-1:0] a, input logic rw, input logic [DW-1:0] d,
                       input logic op, input logic sdc, input logic [1:0] ct, input logic [AW-1:0] ca);
    @(posedge clk_i);
    {addr_o, rw_o, rdata_o, wdata_o} <= {a, rw, d, d ^ 8'h10};
    {valid_o, op_o, sdc_o, cof_o, cof_addr_o} <= {1'b1, op, sdc, ct, ca};
  endtask : start

  task automatic finish();
    @(posedge clk_i);
    {valid_o, op_o, sdc_o, cof_o} <= '0;
    {addr_o, rdata_o, wdata_o, cof_addr_o} <= ~{addr_o, rdata_o, wdata_o, cof_addr_o};
  endtask : finish

  task automatic cycle(input logic [AW-1:0] a, input logic rw, input logic [DW-1:0] d,
                       input logic op, input logic sdc, input logic [1:0] ct, input logic [AW-1:0] ca);
    start(a, rw, d, op, sdc, ct, ca);
    finish();
  endtask : cycle

  task automatic queue(input logic ex, input logic fl);
    @(posedge clk_i);
    {exec_o, flush_o} <= {ex, fl};
    @(posedge clk_i);
    {exec_o, flush_o} <= 2'h0;
  endtask : queue
endmodule : otd_cpu_model

// file: otd_trace_test.sv
// Purpose: Self-checking bench for the bus trace debug unit.
// Assumes: The APB slave answers when pready is high; no wait count is assumed.
// Notes: Low reads after a run also push profile entries, so counts are not checked then.
module otd_trace_test;
  timeunit 1ns;
  timeprecision 1ps;
  import otd_pkg::*;
  logic          clk = 1'h0;
  logic          rst_n = 1'h0;
  logic          psel = 1'h0;
  logic          pen = 1'h0;
  logic          pwr = 1'h0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, rd;
  logic          pready, perr, err;
  logic [AW-1:0] ca, cfa;
  logic [DW-1:0] crd, cwd;
  logic          crw, cv, cop, csdc, cex, cfl, btag, bforce;
  logic [1:0]    cct;
  int            failures = 0, tests_run = 0, cycles = 0, forces = 0, f;
  logic [3:0]    md [12] = '{4'h0, 4'h0, 4'h1, 4'h7, 4'h7, 4'h8, 4'h8, 4'h0, 4'h9, 4'h5, 4'h6, 4'h2};
  logic [15:0]   ad [12] = '{16'h10, 16'h11, 16'h20, 16'h18, 16'h30, 16'h30, 16'h15, 16'h10, 16'h10,
                             16'h10, 16'h10, 16'h20};
  logic [11:0]   ex = 12'h22D;
  logic [11:0]   sd = 12'h080;

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (bforce === 1'h1) forces <= forces + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  otd_trace DUT (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .CPU_ADDR_I(ca), .CPU_RDATA_I(crd), .CPU_WDATA_I(cwd), .CPU_RW_I(crw), .CPU_VALID_I(cv),
    .CPU_OPFETCH_I(cop), .SDC_ACCESS_I(csdc), .QUEUE_EXEC_I(cex), .QUEUE_FLUSH_I(cfl),
    .COF_TYPE_I(cct), .COF_ADDR_I(cfa), .BRK_TAG_O(btag), .BRK_FORCE_O(bforce));
  otd_cpu_model cpu (.clk_i(clk), .addr_o(ca), .rdata_o(crd), .wdata_o(cwd), .rw_o(crw), .valid_o(cv),
    .op_o(cop), .sdc_o(csdc), .exec_o(cex), .flush_o(cfl), .cof_o(cct), .cof_addr_o(cfa));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = perr;
    {psel, pen} <= 2'h0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rdc(REG_CTRL, 32'h0);
    rdc(REG_STATUS, 32'h0);
    apb(1'h1, REG_CMPA, 32'h1234);
    rdc(REG_CMPA, 32'h1234);
    apb(1'h1, REG_STATUS, 32'hFFFF);
    rdc(REG_STATUS, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("registers done");
    // A begin run skips the trigger and two bus cycles, then fills the eight entries.
    apb(1'h1, REG_CTRL, 32'h0009);
    cpu.cycle(16'h1234, 1'h1, 8'h0, 1'h0, 1'h0, COF_BRANCH, 16'hDEAD);
    repeat (2) cpu.cycle(16'h0050, 1'h1, 8'h0, 1'h0, 1'h0, COF_TARGET, 16'hBEEF);
    cpu.cycle(16'h0050, 1'h1, 8'h0, 1'h0, 1'h0, COF_UNCOND, 16'hCAFE);
    for (int i = 0; i < 8; i++) cpu.cycle(16'h60, 1'h1, 8'h0, 1'h0, 1'h0, i[0] ? COF_TARGET : COF_BRANCH, {8'h5A, 8'(i)});
    cpu.cycle(16'h0060, 1'h1, 8'h0, 1'h0, 1'h0, COF_BRANCH, 16'hFACE);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd & 32'hF3, 32'h82);
    for (int i = 0; i < 8; i++) begin
      rdc(REG_FIFO_HI, 32'h5A);
      rdc(REG_FIFO_LO, 32'(i));
    end
    $display("begin run done");
    apb(1'h1, REG_CMPB, 32'h0040);
    apb(1'h1, REG_CTRL, 32'h3001);
    cpu.cycle(16'h0040, 1'h1, 8'hEE, 1'h0, 1'h1, COF_NONE, 16'h0);
    for (int i = 0; i < 8; i++) cpu.cycle(16'h0040, i[0], 8'(8'hA0 + i), 1'h0, 1'h0, COF_NONE, 16'h0);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd & 32'hF1, 32'h80);
    rdc(REG_FIFO_HI, 32'h0);
    for (int i = 0; i < 8; i++) rdc(REG_FIFO_LO, i[0] ? 32'hA0 + i : (32'hA0 + i) ^ 32'h10);
    $display("event run done");
    apb(1'h1, REG_CMPA, 32'h0010);
    apb(1'h1, REG_CMPB, 32'h0020);
    for (int k = 0; k < 12; k++) begin
      apb(1'h1, REG_CTRL, {16'h0, md[k], 12'h003});
      f = forces;
      cpu.cycle(ad[k], 1'h1, 8'h20, 1'h0, sd[k], COF_NONE, 16'h0);
      repeat (3) @(posedge clk);
      chk(32'(forces - f), {31'h0, ex[k]});
    end
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'h1, REG_CTRL, 32'h5023);
    f = forces;
    cpu.cycle(16'h0010, 1'h0, 8'h30, 1'h0, 1'h0, COF_NONE, 16'h0);
    repeat (3) @(posedge clk);
    chk(32'(forces - f), 32'h1);
    apb(1'h1, REG_CTRL, 32'h0007);
    cpu.start(16'h0010, 1'h1, 8'h0, 1'h1, 1'h0, COF_NONE, 16'h0);
    #1 chk({31'h0, btag}, 32'h1);
    cpu.finish();
    cpu.start(16'h0011, 1'h1, 8'h0, 1'h1, 1'h0, COF_NONE, 16'h0);
    #1 chk({31'h0, btag}, 32'h0);
    cpu.finish();
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, REG_CTRL, 32'h0013);
      f = forces;
      cpu.cycle(16'h0010, 1'h1, 8'h0, 1'h1, 1'h0, COF_NONE, 16'h0);
      repeat (3) @(posedge clk);
      chk(32'(forces - f), 32'h0);
      cpu.queue(1'h0, 1'(k));
      cpu.queue(1'h1, 1'h0);
      repeat (3) @(posedge clk);
      chk(32'(forces - f), 32'(1 - k));
    end
    $display("breaks done");
    apb(1'h1, REG_CTRL, 32'h0009);
    cpu.cycle(16'h0010, 1'h1, 8'h0, 1'h0, 1'h0, COF_NONE, 16'h0);
    repeat (2) cpu.cycle(16'h0050, 1'h1, 8'h0, 1'h0, 1'h0, COF_NONE, 16'h0);
    for (int i = 0; i < 3; i++) cpu.cycle(16'h60, 1'h1, 8'h0, 1'h0, 1'h0, COF_BRANCH, {8'h77, 8'(i)});
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd & 32'hF1, 32'h31);
    apb(1'h1, REG_CTRL, 32'h0);
    repeat (4) apb(1'h0, REG_FIFO_LO, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rdc(REG_FIFO_HI, 32'h77);
      rdc(REG_FIFO_LO, 32'(i));
    end
    // The first eight profile reads only fill the FIFO and are thrown away.
    for (int i = 0; i < 8; i++) begin
      cpu.cycle(16'(16'h3000 + i), 1'h1, 8'h0, 1'h1, 1'h0, COF_NONE, 16'h0);
      apb(1'h0, REG_FIFO_LO, 32'h0);
    end
    rdc(REG_FIFO_HI, 32'h30);
    rdc(REG_FIFO_LO, 32'h0);
    $display("halt and profile done");
    end_sim();
  end
endmodule : otd_trace_test
